// *** core/nvsc_cnt.sv ***
// down counter used for access, pulse and recovery timing
// assumes load and run from the controller fsm on one clock
`timescale 1ns/10ps
`default_nettype none
module nvsc_cnt #(
  parameter int W = 8
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rstn_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] value_in,
  output logic              zero_out
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  assign cnt_next = load_in ? value_in : ((cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg);
  assign zero_out = (cnt_reg == '0);
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end
endmodule
`default_nettype wire

// *** core/nvsc_ctrl.sv ***
// host-side controller for a battery-backed 128k x 8 asynchronous sram
// assumes pins synchronous to ref_clk_in; data bus resolved by the bench
//
// Overview of operation
// R1 - read: write strobe high, select and output drive low, device drives data
// R2 - device decodes the 17-bit address to one of 131072 bytes
// R3 - read data is valid an address access time after address settles
// R4 - late select or output drive times data from the later one
// R5 - write: address settled first, then write strobe and select low
// R6 - write runs from later falling strobe to earlier rising strobe
// R7 - host keeps the address stable during the whole write
// R8 - host holds write strobe high for write recovery before next access
// R9 - host keeps output drive high throughout writes to avoid contention
// R10 - device floats data within float time of falling write strobe
// R11 - device accepts writes above 3.0 volts, blocks them by 2.8 volts
// R12 - on supply decay device ignores inputs and floats outputs
// R13 - device switches to backup below about 2.5 volts
// R14 - device asserts power fail reset low on bad supply
// R15 - power fail reset held about 200 ms at power-up; the model releases it as soon as supply is up
// R16 - device tests battery daily, suspended while power has failed
// R17 - battery test loads for 1 second, below 2.6V asserts battery low
// R18 - battery low stays latched until replacement or passing retest
// R19 - battery retested at each power-up, pass clears battery low
// R20 - backup source disconnected until supply first applied
// R21 - power fail reset released 150 to 350 ms after supply valid; the model releases it with no delay
// R22 - select high means no access and a floating data bus
// R23 - long device intervals are counted on a free-running clock
`timescale 1ns/10ps
`default_nettype none
`include "nvsc_regs.svh"
module nvsc_ctrl #(
  parameter int ACC_CYC  = `NVSC_ACC_CYC,
  parameter int WP_CYC   = `NVSC_WP_CYC,
  parameter int REC_CYC  = `NVSC_REC_CYC,
  parameter int ODW_CYC  = `NVSC_ODW_CYC,
  parameter int RST_MAX_CYC = `NVSC_RST_MAX_CYC
) (
  input  wire logic                    ref_clk_in,
  input  wire logic                    rstn_in,
  input  wire logic                    req_valid_in,
  input  wire logic                    req_write_in,
  input  wire logic [`NVSC_ADDR_W-1:0] req_addr_in,
  input  wire logic [`NVSC_DATA_W-1:0] req_wdata_in,
  output logic                         req_ready_out,
  output logic                         rsp_valid_out,
  output logic [`NVSC_DATA_W-1:0]      rsp_rdata_out,
  output logic                         dev_ready_out,
  output logic                         batt_low_out,
  output logic                         rst_timeout_out,
  output logic [`NVSC_ADDR_W-1:0]      byte_address_out,
  output logic                         chip_select_n_out,
  output logic                         write_strobe_n_out,
  output logic                         output_drive_n_out,
  input  wire logic [`NVSC_DATA_W-1:0] data_bus_in,
  output logic [`NVSC_DATA_W-1:0]      data_bus_out,
  output logic                         data_bus_oe_n_out,
  input  wire logic                    power_fail_reset_n_in,
  input  wire logic                    battery_low_n_in
);
  //////////////////////////////////////////////////////////////////////////
  nvsc_pkg::nvsc_state_t state_reg;
  nvsc_pkg::nvsc_state_t state_next;
  logic [`NVSC_ADDR_W-1:0] addr_reg;
  logic [`NVSC_DATA_W-1:0] wdata_reg;
  logic [`NVSC_DATA_W-1:0] rdata_reg;
  logic                    rvalid_reg;
  logic [31:0]             rst_cnt_reg;
  logic                    tmo_reg;
  logic                    cnt_load;
  logic [7:0]              cnt_value;
  logic                    cnt_zero;
  wire                     dev_ok;
  wire                     take;
  wire                     in_write;
  // device resets low while supply is bad; any access then is pointless
  assign dev_ok   = power_fail_reset_n_in; // see R14 see R21
  assign take     = (state_reg == nvsc_pkg::ST_IDLE) && req_valid_in && dev_ok;
  assign in_write = (state_reg == nvsc_pkg::ST_WSET) || (state_reg == nvsc_pkg::ST_WPULS) ||
                    (state_reg == nvsc_pkg::ST_WREC);
  nvsc_cnt #(
    .W (8)
  ) u_cnt (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .load_in    (cnt_load),
    .value_in   (cnt_value),
    .zero_out   (cnt_zero)
  );
  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    cnt_load   = 1'b0;
    cnt_value  = 8'h00;
    unique case (state_reg)
      nvsc_pkg::ST_IDLE:
        if (take)
        begin
          cnt_load   = 1'b1;
          // one setup cycle of address before the write strobe falls
          cnt_value  = req_write_in ? 8'h00 : 8'(ACC_CYC); // see R3 see R4
          state_next = req_write_in ? nvsc_pkg::ST_WSET : nvsc_pkg::ST_RD;
        end
      nvsc_pkg::ST_RD:
        if (cnt_zero)
          state_next = nvsc_pkg::ST_DONE;
      nvsc_pkg::ST_WSET:
      begin
        cnt_load   = 1'b1;
        cnt_value  = 8'(WP_CYC - 1);
        state_next = nvsc_pkg::ST_WPULS; // see R5
      end
      nvsc_pkg::ST_WPULS:
        if (cnt_zero)
        begin
          cnt_load   = 1'b1;
          cnt_value  = 8'(REC_CYC - 1);
          state_next = nvsc_pkg::ST_WREC; // see R6
        end
      nvsc_pkg::ST_WREC:
        if (cnt_zero)
          state_next = nvsc_pkg::ST_DONE; // see R8
      nvsc_pkg::ST_DONE:
        state_next = nvsc_pkg::ST_IDLE;
      default:
        state_next = nvsc_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      state_reg <= nvsc_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end
  // address and data latched once, held for the whole access
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      addr_reg  <= '0;
      wdata_reg <= '0;
    end
    else if (take)
    begin
      addr_reg  <= req_addr_in; // see R7 see R2
      wdata_reg <= req_wdata_in;
    end
  end
  // sample read data on the last access cycle, after full access time
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rdata_reg  <= `NVSC_RDATA_RST;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= (state_reg == nvsc_pkg::ST_RD) && cnt_zero;
      if ((state_reg == nvsc_pkg::ST_RD) && cnt_zero)
        rdata_reg <= data_bus_in; // see R1 see R3
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // reset watchdog: device must release within the longest hold time
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_cnt_reg <= 32'h00000000;
      tmo_reg     <= 1'b0;
    end
    else if (power_fail_reset_n_in)
    begin
      rst_cnt_reg <= 32'h00000000;
      tmo_reg     <= 1'b0;
    end
    else if (rst_cnt_reg < 32'(RST_MAX_CYC))
      rst_cnt_reg <= rst_cnt_reg + 32'h00000001; // see R23 see R21
    else
      tmo_reg <= 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////
  assign byte_address_out   = addr_reg;
  // select only during an access; idle leaves the device deselected
  assign chip_select_n_out  = !((state_reg == nvsc_pkg::ST_RD) ||
                                (state_reg == nvsc_pkg::ST_WPULS));
  assign write_strobe_n_out = !(state_reg == nvsc_pkg::ST_WPULS); // see R6
  assign output_drive_n_out = !(state_reg == nvsc_pkg::ST_RD); // see R9
  assign data_bus_out       = wdata_reg;
  // drive the bus across setup, pulse and hold, never while reading
  assign data_bus_oe_n_out  = !in_write; // see R9 see R5
  assign req_ready_out      = (state_reg == nvsc_pkg::ST_IDLE) && dev_ok;
  assign rsp_valid_out      = rvalid_reg;
  assign rsp_rdata_out      = rdata_reg;
  assign dev_ready_out      = dev_ok;
  assign batt_low_out       = !battery_low_n_in; // see R18
  assign rst_timeout_out    = tmo_reg;
  //////////////////////////////////////////////////////////////////////////
  a_no_contention: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    !(!data_bus_oe_n_out && !output_drive_n_out)) // see R9
    else $error("host drives bus while device output enabled");
  a_write_pulse: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    $fell(write_strobe_n_out) |-> !write_strobe_n_out [*2]) // see R6
    else $error("write pulse too short");
  a_write_recov: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    $rose(write_strobe_n_out) |-> chip_select_n_out ##1 chip_select_n_out) // see R8
    else $error("write recovery violated");
  a_addr_stable: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    !write_strobe_n_out |-> $stable(byte_address_out)) // see R7
    else $error("address moved during write");
  a_read_strobes: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    !output_drive_n_out |-> write_strobe_n_out && !chip_select_n_out) // see R1
    else $error("bad read strobe combination");
  a_read_time: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    $fell(output_drive_n_out) |-> !output_drive_n_out [*4] ##1 rsp_valid_out) // see R3
    else $error("read sampled at wrong time");
  a_addr_setup: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    $fell(write_strobe_n_out) |-> $stable(byte_address_out) && !data_bus_oe_n_out) // see R5
    else $error("address or data not set up before write");
  a_rst_gate: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // see R14
    !power_fail_reset_n_in && (state_reg == nvsc_pkg::ST_IDLE)
    |=> chip_select_n_out && data_bus_oe_n_out)
    else $error("access started while device in reset");
  c_read: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) rsp_valid_out);
  c_write: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) $rose(write_strobe_n_out));
  c_timeout: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) $rose(rst_timeout_out));
endmodule
`default_nettype wire

// *** core/nvsc_pkg.sv ***
// types for the nv sram controller
// no timescale: package only
package nvsc_pkg;
  typedef enum logic [5:0]
  {
    ST_IDLE  = 6'b000001,
    ST_RD    = 6'b000010,
    ST_WSET  = 6'b000100,
    ST_WPULS = 6'b001000,
    ST_WREC  = 6'b010000,
    ST_DONE  = 6'b100000
  } nvsc_state_t;
endpackage

// *** core/nvsc_regs.svh ***
// timing constants, field widths and reset values for the nv sram controller
// assumes a 20 MHz reference clock, period 50 ns
`ifndef NVSC_REGS_SVH
`define NVSC_REGS_SVH
`define NVSC_CLK_PERIOD_NS     50
`define NVSC_ADDR_W            17
`define NVSC_DATA_W            8
// access times in ns (slowest speed grade)
`define NVSC_ACC_TIME_NS       150
`define NVSC_WP_TIME_NS        100
`define NVSC_WR_REC_TIME_NS    20
`define NVSC_ODW_TIME_NS       35
// derived cycle counts: least times round up, at least one cycle
`define NVSC_ACC_CYC  ((`NVSC_ACC_TIME_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
`define NVSC_WP_CYC   ((`NVSC_WP_TIME_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
`define NVSC_REC_CYC  ((`NVSC_WR_REC_TIME_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
`define NVSC_ODW_CYC  ((`NVSC_ODW_TIME_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
// power-fail reset hold window from the device, in ms
`define NVSC_RST_MAX_MS        350
`define NVSC_RST_MAX_CYC       (`NVSC_RST_MAX_MS * 20000)
`define NVSC_RDATA_RST         8'h00
`endif

// *** verif/nvsc_ctrl_tb.sv ***
// self-checking bench for the nv sram host controller
// assumes nvsc_ctrl and nvsc_dev_model compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "nvsc_regs.svh"
module nvsc_ctrl_tb;
  logic        ref_clk, rstn, req_valid, req_write, req_ready, rsp_valid, dev_ready, batt_low;
  logic        rst_to, cs_n, we_n, od_n, oe_n, pf_n, bl_n, dev_drv, supply_ok, batt_weak, wp;
  logic [16:0] req_addr, bus_addr, wa;
  logic [7:0]  req_wdata, rsp_rdata, bus_in, host_q, dev_q;
  int          error_cnt = 0, num_checks = 0;
  logic [7:0]  ref_mem [int];
  logic [16:0] addr_q [$];
  ////////////////////////////////////////////////////////////////////////////
  assign bus_in = oe_n ? dev_q : host_q;
  nvsc_ctrl #(.RST_MAX_CYC(50)) i_nvsc_ctrl (.ref_clk_in(ref_clk), .rstn_in(rstn),
    .req_valid_in(req_valid), .req_write_in(req_write), .req_addr_in(req_addr),
    .req_wdata_in(req_wdata), .req_ready_out(req_ready), .rsp_valid_out(rsp_valid),
    .rsp_rdata_out(rsp_rdata), .dev_ready_out(dev_ready), .batt_low_out(batt_low),
    .rst_timeout_out(rst_to), .byte_address_out(bus_addr), .chip_select_n_out(cs_n),
    .write_strobe_n_out(we_n), .output_drive_n_out(od_n), .data_bus_in(bus_in),
    .data_bus_out(host_q), .data_bus_oe_n_out(oe_n), .power_fail_reset_n_in(pf_n),
    .battery_low_n_in(bl_n));
  nvsc_dev_model i_nvsc_dev_model (.byte_address_in(bus_addr), .chip_select_n_in(cs_n),
    .write_strobe_n_in(we_n), .output_drive_n_in(od_n), .data_bus_in(bus_in),
    .supply_ok_in(supply_ok), .batt_weak_in(batt_weak), .data_bus_out(dev_q),
    .data_drive_out(dev_drv), .power_fail_reset_n_out(pf_n), .battery_low_n_out(bl_n));
  always #25 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t bit got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t byte got %h expected %h", $time, got, exp);
    end
  endtask
  // called at a falling edge; request held until the edge that takes it
  task automatic access(input logic wr, input logic [16:0] a, input logic [7:0] d);
    int n;
    req_valid = 1'b1; req_write = wr; req_addr = a; req_wdata = d;
    n = 0;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk_bit(req_ready, 1'b1);
    @(posedge ref_clk);
    @(negedge ref_clk);
    req_valid = 1'b0;
    n = 1;
    while (!wr && rsp_valid !== 1'b1 && n < 10)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (!wr) chk_bit(logic'(n == 5), 1'b1);
    // valid stays low a full cycle between back-to-back writes
    if (wr) @(negedge ref_clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // host-side pin discipline, watched on every rising edge
  always @(posedge ref_clk)
    if (rstn)
    begin
      chk_bit(logic'(!oe_n && dev_drv), 1'b0);
      if (wp && !cs_n && !we_n) chk_bit(logic'(bus_addr === wa), 1'b1);
      wp <= !cs_n && !we_n;
      wa <= bus_addr;
    end
  initial
  begin
    #2000000;
    error_cnt++;
    end_sim();
  end
  initial
  begin
    logic [16:0] a;
    logic [7:0]  d;
    ref_clk = 0; rstn = 0; req_valid = 0; req_write = 0; req_addr = 0; req_wdata = 0;
    supply_ok = 0; batt_weak = 0; wp = 0; wa = 0;
    // supply comes up inside reset so the model arms its backup source
    repeat (2) @(negedge ref_clk);
    supply_ok = 1;
    repeat (10) @(negedge ref_clk);
    chk_bit(cs_n & we_n & od_n & oe_n, 1'b1);
    rstn = 1;
    void'($urandom(32'hd0e5711a));
    for (int i = 0; i < 12; i++)
    begin
      a = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1ffff : 17'($urandom);
      d = 8'($urandom);
      addr_q.push_back(a);
      ref_mem[int'(a)] = d;
      access(1'b1, a, d);
    end
    foreach (addr_q[k])
    begin
      access(1'b0, addr_q[k], 8'h00);
      chk_byte(rsp_rdata, ref_mem[int'(addr_q[k])]);
    end
    $display("test readback done");
    supply_ok = 0;
    @(negedge ref_clk);
    chk_bit(dev_ready, 1'b0);
    chk_bit(req_ready, 1'b0);
    req_valid = 1; req_write = 0; req_addr = addr_q[0];
    repeat (40) @(negedge ref_clk);
    chk_bit(cs_n, 1'b1);
    chk_bit(rst_to, 1'b0);
    repeat (20) @(negedge ref_clk);
    chk_bit(rst_to, 1'b1);
    supply_ok = 1;
    access(1'b0, addr_q[0], 8'h00);
    chk_byte(rsp_rdata, ref_mem[int'(addr_q[0])]);
    chk_bit(rst_to, 1'b0);
    $display("test device reset done");
    batt_weak = 1;
    @(negedge ref_clk);
    chk_bit(batt_low, 1'b1);
    batt_weak = 0;
    @(negedge ref_clk);
    chk_bit(batt_low, 1'b1);
    supply_ok = 0;
    @(negedge ref_clk);
    supply_ok = 1;
    @(negedge ref_clk);
    chk_bit(batt_low, 1'b0);
    $display("test battery warning done");
    end_sim();
  end
endmodule
`default_nettype wire

// *** verif/nvsc_dev_model.sv ***
// pin-level model of the battery-backed 128k x 8 sram and its supervisor
// assumes the bench resolves the shared data bus from the host drive enable alone
`timescale 1ns/10ps
`default_nettype none
`include "nvsc_regs.svh"
module nvsc_dev_model (
  input  wire logic [`NVSC_ADDR_W-1:0] byte_address_in,
  input  wire logic                    chip_select_n_in,
  input  wire logic                    write_strobe_n_in,
  input  wire logic                    output_drive_n_in,
  input  wire logic [`NVSC_DATA_W-1:0] data_bus_in,
  input  wire logic                    supply_ok_in,
  input  wire logic                    batt_weak_in,
  output logic [`NVSC_DATA_W-1:0]      data_bus_out,
  output logic                         data_drive_out,
  output logic                         power_fail_reset_n_out,
  output logic                         battery_low_n_out
);
  logic [`NVSC_DATA_W-1:0] mem [int];
  logic [`NVSC_DATA_W-1:0] last_q = 8'h00;
  logic                    wr_act;
  logic                    data_ok = 1'b0;
  logic                    batt_flag = 1'b0;
  logic                    armed = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  assign power_fail_reset_n_out = supply_ok_in;
  assign battery_low_n_out = ~batt_flag;
  // a weak result only counts while supply is up; testing pauses on power loss
  always @(posedge batt_weak_in) if (supply_ok_in) batt_flag = 1'b1;
  // every power-up retests, a good battery clears the latched warning
  always @(posedge supply_ok_in) batt_flag = batt_weak_in;
  // backup only armed once supply was seen; before that a supply loss wipes memory
  always @(posedge supply_ok_in) armed = 1'b1;
  always @(negedge supply_ok_in) if (!armed) mem.delete();
  // data stays invalid until the slowest access time has passed
  always @(byte_address_in or data_drive_out)
  begin
    data_ok = 1'b0;
    data_ok <= #(`NVSC_ACC_TIME_NS) data_drive_out;
  end
  assign wr_act = ~chip_select_n_in & ~write_strobe_n_in & supply_ok_in;
  assign data_drive_out = ~chip_select_n_in & ~output_drive_n_in & write_strobe_n_in
                          & supply_ok_in;
  // store at the earlier rising strobe, i.e. when the write window closes
  always @(negedge wr_act) mem[int'(byte_address_in)] = data_bus_in;
  // released bus shows the inverse of the last byte, never a kind constant
  always @*
    if (data_drive_out && data_ok)
      data_bus_out = mem.exists(int'(byte_address_in)) ? mem[int'(byte_address_in)] : 8'h5a;
    else
      data_bus_out = ~last_q;
  always @(data_bus_out) if (data_drive_out) last_q = data_bus_out;
endmodule
`default_nettype wire
